// ===== dv/shcs_port_props.sv
// Checker for the sensor host command port
`timescale 1ns/100ps
module shcs_port_props (
	input wire clock,
	input wire rst_n,
	input wire spi_miso_oe,
	input wire meas_req,
	input wire [1:0] meas_type,
	input wire meas_use_host_setup,
	input wire [15:0] meas_setup,
	input wire meas_done,
	input wire [15:0] meas_data,
	input wire [1:0] mode_reg,
	input wire eoc_reg,
	input wire i2c_mode,
	input wire [7:0] response_status_byte,
	input wire [15:0] response_data_reg,
	input wire cmd_seen
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire busy = response_status_byte[5];
	fixed_bits_a: assert property (response_status_byte[7:6] == 2'b01)
		else $error("fixed bits");
	mode_bits_a: assert property (response_status_byte[4:3] == mode_reg)
		else $error("mode bits");
	busy_on_req_a: assert property (meas_req |-> busy)
		else $error("busy at request");
	no_cmd_busy_a: assert property (cmd_seen |-> !$past(busy))
		else $error("taken while busy");
	done_data_a: assert property (meas_done && busy |=> response_data_reg == $past(meas_data) && !busy)
		else $error("result");
	eoc_set_a: assert property (meas_done && busy |=> eoc_reg)
		else $error("eoc");
	temp_mask_a: assert property (meas_req && meas_type[1] && meas_use_host_setup |-> meas_setup[15:13] == 3'b000)
		else $error("setup mask");
	i2c_quiet_a: assert property (i2c_mode |-> !spi_miso_oe && !meas_req)
		else $error("spi in i2c");
	integ_hold_a: assert property ($past(rst_n, 3) |-> $stable(response_status_byte[2]))
		else $error("integrity bit");
endmodule // shcs_port_props
bind shcs_port shcs_port_props u_props (.clock(clock), .rst_n(rst_n), .spi_miso_oe(spi_miso_oe),
	.meas_req(meas_req), .meas_type(meas_type), .meas_use_host_setup(meas_use_host_setup),
	.meas_setup(meas_setup), .meas_done(meas_done), .meas_data(meas_data), .mode_reg(mode_reg),
	.eoc_reg(eoc_reg), .i2c_mode(i2c_mode), .response_status_byte(response_status_byte),
	.response_data_reg(response_data_reg), .cmd_seen(cmd_seen));

// ===== dv/shcs_spi_master.sv
// SPI master model, modes 0..3, either select polarity
`timescale 1ns/100ps
module shcs_spi_master (
	input wire clock,
	input wire cpol,
	input wire cpha,
	input wire ss_pol,
	output reg spi_sclk,
	output reg spi_ss,
	output reg spi_mosi,
	input wire spi_miso
);
	initial begin
		spi_sclk = 1'b0;
		spi_ss = 1'b1;
		spi_mosi = 1'b0;
	end
	// One 24-bit frame MSB first, 80 ns bit period
	task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
		@(posedge clock);
		spi_sclk <= cpol;
		spi_ss <= ~ss_pol;
		repeat (6) @(posedge clock);
		spi_ss <= ss_pol;
		repeat (6) @(posedge clock);
		for (int i = 23; i >= 0; i--) begin
			if (cpha) spi_sclk <= ~cpol;
			spi_mosi <= tx[i];
			repeat (10) @(posedge clock);
			rx[i] = spi_miso;
			spi_sclk <= cpha ? cpol : ~cpol;
			repeat (10) @(posedge clock);
			if (!cpha) spi_sclk <= cpol;
		end
		repeat (10) @(posedge clock);
		spi_ss <= ~ss_pol;
		// Released line shows the inverse of the last bit
		spi_mosi <= ~spi_mosi;
		repeat (8) @(posedge clock);
	endtask
endmodule // shcs_spi_master

// ===== dv/tb_shcs_port.sv
// Self-checking bench for the sensor host command port
`timescale 1ns/100ps
module tb_shcs_port;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic if_sel = 1'b0;
	logic integrity_fail = 1'b0;
	logic [15:0] bridge_setup_word = 16'h1234;
	logic meas_done = 1'b0;
	logic mem_done = 1'b0;
	logic mem_corrected = 1'b0;
	logic mem_reject = 1'b0;
	logic [15:0] if_config_word = 16'h0000;
	logic [15:0] meas_data = 16'h0000;
	logic [23:0] rx;
	wire spi_sclk, spi_ss, spi_mosi, spi_miso, meas_req, mem_req, meas_use_host_setup, eoc_reg;
	wire [1:0] meas_type;
	wire [15:0] meas_setup, response_data_reg;
	wire [7:0] response_status_byte;
	int fail_count = 0;
	int num_checks = 0;
	int req_count = 0;
	always #2 clock = ~clock;
	always @(posedge clock) if (meas_req === 1'b1 || mem_req === 1'b1) req_count++;
	shcs_spi_master u_mst (.clock(clock), .cpol(if_config_word[11]), .cpha(if_config_word[10]),
		.ss_pol(if_config_word[9]), .spi_sclk(spi_sclk), .spi_ss(spi_ss),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso));
	shcs_port u_dut (.clock(clock), .rst_n(rst_n), .clk_en(1'b1), .if_sel(if_sel),
		.spi_sclk(spi_sclk), .spi_ss(spi_ss), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
		.spi_miso_oe(), .if_config_word(if_config_word), .bridge_setup_word(bridge_setup_word),
		.integrity_fail(integrity_fail), .meas_req(meas_req), .meas_type(meas_type),
		.meas_use_host_setup(meas_use_host_setup), .meas_setup(meas_setup), .meas_full(),
		.meas_done(meas_done), .meas_data(meas_data), .meas_saturated(1'b0), .mem_req(mem_req),
		.mem_write(), .mem_status_query(), .mem_addr(), .mem_wdata(), .page_inc_req(),
		.mem_done(mem_done), .mem_rdata(meas_data), .mem_corrected(mem_corrected),
		.mem_reject(mem_reject), .mode_reg(), .eoc_reg(eoc_reg), .i2c_mode(),
		.response_status_byte(response_status_byte), .response_data_reg(response_data_reg),
		.cmd_seen());
	// ==========
	// Helpers
	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic wait_req(input int n);
		repeat (300) begin
			@(posedge clock);
			#1;
			if (req_count == n) return;
		end
		check("request", 24'h0, 24'h1);
		conclude();
	endtask
	task automatic finish_op(input logic m, input logic [15:0] d);
		@(posedge clock);
		meas_done <= !m;
		mem_done <= m;
		mem_corrected <= m;
		meas_data <= d;
		@(posedge clock);
		meas_done <= 1'b0;
		mem_done <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
	endtask
	task automatic do_reset(input logic f);
		@(posedge clock);
		rst_n <= 1'b0;
		integrity_fail <= f;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		#1;
	endtask
	// ==========
	// Scenarios
	task automatic t_reset;
		do_reset(1'b1);
		@(posedge clock);
		integrity_fail <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		check("integrity", 24'(response_status_byte), 24'h4C);
		do_reset(1'b0);
		check("status", 24'(response_status_byte), 24'h48);
		$display("t_reset done");
	endtask
	task automatic t_raw;
		logic [7:0] code;
		int n;
		for (int k = 0; k < 8; k++) begin
			code = 8'hA0 + 8'(k);
			n = req_count;
			u_mst.frame({code, code[0] ? 16'hFFFF : 16'h0000}, rx);
			wait_req(n + 1);
			check("type", 24'(meas_type), 24'(code[2:1]));
			check("host", 24'(meas_use_host_setup), 24'(code[0]));
			if (code[0]) check("setup", 24'(meas_setup), code[2] ? 24'h1FFF : 24'hFFFF);
			else if (!code[2]) check("stored", 24'(meas_setup), 24'(bridge_setup_word));
			u_mst.frame({8'hA0, 16'h0000}, rx);
			check("busy", 24'(rx[21]), 24'h1);
			finish_op(1'b0, 16'h5A00 + 16'(k));
			check("eoc", 24'(eoc_reg), 24'h1);
			u_mst.frame({8'hF0, 16'h0000}, rx);
			check("reply", {rx[23:19], 3'b0, rx[15:0]}, {8'h48, 16'h5A00 + 16'(k)});
			u_mst.frame({8'hFF, 16'h0000}, rx);
			check("again", 24'(rx[15:0]), 24'h5A00 + 24'(k));
			check("count", 24'(req_count), 24'(n + 1));
		end
		$display("t_raw done");
	endtask
	task automatic t_mem;
		int n;
		n = req_count;
		u_mst.frame({8'h03, 16'h0000}, rx);
		wait_req(n + 1);
		check("cleared", 24'(response_data_reg), 24'h0);
		finish_op(1'b1, 16'hBEEF);
		u_mst.frame({8'hF3, 16'h0000}, rx);
		check("read", rx, {8'h4A, 16'hBEEF});
		for (int r = 1; r >= 0; r--) begin
			@(posedge clock);
			mem_reject <= 1'(r);
			n = req_count;
			u_mst.frame({8'h45, 16'h1357}, rx);
			wait_req(n + 1);
			finish_op(1'b1, 16'h0000);
			u_mst.frame({8'hF0, 16'h0000}, rx);
			check("write", rx, {6'h12, 1'(r), 1'b0, 16'h0000});
		end
		u_mst.frame({8'hA8, 16'h0000}, rx);
		u_mst.frame({8'hF0, 16'h0000}, rx);
		check("normal", 24'(rx[23:16]), 24'h40);
		u_mst.frame({8'hA9, 16'h0000}, rx);
		u_mst.frame({8'hF0, 16'h0000}, rx);
		check("command", 24'(rx[23:16]), 24'h48);
		$display("t_mem done");
	endtask
	task automatic t_modes;
		int n;
		for (int m = 1; m < 8; m++) begin
			@(posedge clock);
			if_config_word <= 16'(m) << 9;
			repeat (4) @(posedge clock);
			n = req_count;
			u_mst.frame({8'h05, 16'h0000}, rx);
			wait_req(n + 1);
			finish_op(1'b1, 16'hC0D0 + 16'(m));
			u_mst.frame({8'hF5, 16'h0000}, rx);
			check("spi mode", rx, {8'h4A, 16'hC0D0 + 16'(m)});
		end
		@(posedge clock);
		if_config_word <= 16'h0000;
		repeat (4) @(posedge clock);
		$display("t_modes done");
	endtask
	task automatic t_i2c;
		int n;
		n = req_count;
		@(posedge clock);
		if_sel <= 1'b1;
		repeat (4) @(posedge clock);
		u_mst.frame({8'hA0, 16'h0000}, rx);
		repeat (20) @(posedge clock);
		check("i2c", 24'(req_count), 24'(n));
		$display("t_i2c done");
	endtask
	initial begin
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		t_reset();
		t_raw();
		t_mem();
		t_modes();
		t_i2c();
		conclude();
	end
endmodule // tb_shcs_port

// ===== rtl/shcs_port.v
// Command interpreter and status front end of the sensor conditioner
`timescale 1ns/100ps
`include "shcs_regs.vh"
module shcs_port (
	input wire clock,
	input wire rst_n,
	input wire clk_en,
	input wire if_sel,
	input wire spi_sclk,
	input wire spi_ss,
	input wire spi_mosi,
	output wire spi_miso,
	output wire spi_miso_oe,
	input wire [15:0] if_config_word,
	input wire [15:0] bridge_setup_word,
	input wire integrity_fail,
	output reg meas_req,
	output reg [1:0] meas_type,
	output reg meas_use_host_setup,
	output reg [15:0] meas_setup,
	output reg meas_full,
	input wire meas_done,
	input wire [15:0] meas_data,
	input wire meas_saturated,
	output reg mem_req,
	output reg mem_write,
	output reg mem_status_query,
	output reg [4:0] mem_addr,
	output reg [15:0] mem_wdata,
	output reg page_inc_req,
	input wire mem_done,
	input wire [15:0] mem_rdata,
	input wire mem_corrected,
	input wire mem_reject,
	output reg [1:0] mode_reg,
	output reg eoc_reg,
	output wire i2c_mode,
	output wire [7:0] response_status_byte,
	output reg [15:0] response_data_reg,
	output reg cmd_seen
);
	// ==========================================
	// Pin synchronisers
	// ==========================================
	wire [3:0] pins_s;
	shcs_sync #(.WIDTH(4)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.async_in({if_sel, spi_sclk, spi_ss, spi_mosi}),
		.sync_out(pins_s)
	);
	wire sel_s = pins_s[3];
	assign i2c_mode = sel_s;
	// ==========================================
	// Serial shifter
	// ==========================================
	wire sel_active;
	wire frame_start;
	wire frame_end;
	wire [23:0] rx_word;
	wire [4:0] rx_count;
	wire miso_bit;
	shcs_spi_shift u_shift (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.sclk_s(pins_s[2]),
		.ss_s(pins_s[1]),
		.mosi_s(pins_s[0]),
		.cpol(if_config_word[`SHCS_CFG_CPOL]),
		.cpha(if_config_word[`SHCS_CFG_CPHA]),
		.ss_active_high(if_config_word[`SHCS_CFG_SSPOL]),
		.tx_word({response_status_byte, response_data_reg}),
		.miso_reg(miso_bit),
		.sel_active(sel_active),
		.frame_start(frame_start),
		.frame_end(frame_end),
		.rx_reg(rx_word),
		.rx_count_reg(rx_count)
	);
	assign spi_miso = miso_bit;
	assign spi_miso_oe = ~sel_s & sel_active;
	// ==========================================
	// Status flags
	// ==========================================
	reg busy_reg;
	reg memerr_reg;
	reg memerr_taken_reg;
	reg xfer_reg;
	reg sat_reg;
	reg data_valid_reg;
	assign response_status_byte = {1'b0, 1'b1, busy_reg, mode_reg, memerr_reg,
		xfer_reg, sat_reg};
	// ==========================================
	// Command decode
	// ==========================================
	localparam ST_IDLE = 3'b001;
	localparam ST_MEAS = 3'b010;
	localparam ST_MEM = 3'b100;
	reg [2:0] state_reg;
	wire [7:0] cmd = rx_word[23:16];
	wire [15:0] arg = rx_word[15:0];
	wire is_nop = (cmd & `SHCS_CMD_NOP_MASK) == `SHCS_CMD_NOP_BASE;
	wire is_raw = (cmd & `SHCS_CMD_RAW_MASK) == `SHCS_CMD_RAW_BASE;
	wire is_cmd_mode = mode_reg == `SHCS_MODE_CMD;
	wire is_rd = cmd <= `SHCS_CMD_RD_MAX;
	wire is_mst = cmd >= `SHCS_CMD_MST_BASE && cmd <= `SHCS_CMD_MST_MAX;
	wire is_wr = cmd >= `SHCS_CMD_WR_BASE && cmd <= `SHCS_CMD_WR_MAX;
	// Command taken at frame end once the command byte has fully arrived
	wire cmd_valid = frame_end && !sel_s && rx_count >= 5'h08;
	wire [7:0] cmd_one = rx_count >= 5'h18 ? cmd : rx_word[7:0];
	wire [15:0] arg_use = rx_count >= 5'h18 ? arg : 16'h0000;
	wire [4:0] cmd_addr = cmd_one[4:0];
	wire [15:0] temp_setup = {3'b000, arg_use[`SHCS_TEMP_SETUP_MSB:0]};
	always @(posedge clock) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			busy_reg <= 1'b0;
			mode_reg <= `SHCS_MODE_CMD;
			memerr_reg <= 1'b0;
			memerr_taken_reg <= 1'b0;
			xfer_reg <= 1'b0;
			sat_reg <= 1'b0;
			data_valid_reg <= 1'b0;
			response_data_reg <= 16'h0000;
			eoc_reg <= 1'b0;
			meas_req <= 1'b0;
			meas_type <= `SHCS_CONV_BRIDGE;
			meas_use_host_setup <= 1'b0;
			meas_setup <= 16'h0000;
			meas_full <= 1'b0;
			mem_req <= 1'b0;
			mem_write <= 1'b0;
			mem_status_query <= 1'b0;
			mem_addr <= 5'h00;
			mem_wdata <= 16'h0000;
			page_inc_req <= 1'b0;
			cmd_seen <= 1'b0;
		end else if (clk_en) begin
			meas_req <= 1'b0;
			mem_req <= 1'b0;
			page_inc_req <= 1'b0;
			cmd_seen <= 1'b0;
			if (!memerr_taken_reg) begin
				memerr_reg <= integrity_fail;
				memerr_taken_reg <= 1'b1;
			end
			case (state_reg)
			ST_IDLE: begin
				// Busy gate: frames while busy are dropped
				if (cmd_valid && !busy_reg && !(cmd_one[7:4] == 4'hF)) begin
					cmd_seen <= 1'b1;
					data_valid_reg <= 1'b0;
					response_data_reg <= 16'h0000;
					if ((cmd_one & `SHCS_CMD_RAW_MASK) == `SHCS_CMD_RAW_BASE) begin
						meas_type <= cmd_one[2:1];
						meas_use_host_setup <= cmd_one[0];
						if (!cmd_one[0])
							meas_setup <= bridge_setup_word;
						else if (cmd_one[2])
							meas_setup <= temp_setup;
						else
							meas_setup <= arg_use;
						meas_full <= 1'b0;
						meas_req <= 1'b1;
						eoc_reg <= 1'b0;
						busy_reg <= 1'b1;
						state_reg <= ST_MEAS;
					end else if (cmd_one == `SHCS_CMD_MEASURE) begin
						meas_full <= 1'b1;
						meas_req <= 1'b1;
						eoc_reg <= 1'b0;
						busy_reg <= 1'b1;
						state_reg <= ST_MEAS;
					end else if (cmd_one == `SHCS_CMD_START_NOM && is_cmd_mode) begin
						mode_reg <= `SHCS_MODE_NORMAL;
					end else if (cmd_one == `SHCS_CMD_START_CM && !is_cmd_mode) begin
						mode_reg <= `SHCS_MODE_CMD;
					end else if (cmd_one == `SHCS_CMD_PAGE_INC && is_cmd_mode) begin
						page_inc_req <= 1'b1;
						mem_write <= 1'b1;
						busy_reg <= 1'b1;
						state_reg <= ST_MEM;
					end else if (cmd_one <= `SHCS_CMD_RD_MAX
						|| (cmd_one >= `SHCS_CMD_MST_BASE && cmd_one <= `SHCS_CMD_MST_MAX)
						|| (is_cmd_mode && cmd_one >= `SHCS_CMD_WR_BASE
						&& cmd_one <= `SHCS_CMD_WR_MAX)) begin
						mem_req <= 1'b1;
						mem_write <= cmd_one[6];
						mem_status_query <= cmd_one[5];
						mem_addr <= cmd_addr;
						mem_wdata <= arg_use;
						busy_reg <= 1'b1;
						state_reg <= ST_MEM;
					end
				end
			end
			ST_MEAS: begin
				if (meas_done) begin
					response_data_reg <= meas_data;
					sat_reg <= meas_saturated;
					data_valid_reg <= 1'b1;
					busy_reg <= 1'b0;
					eoc_reg <= 1'b1;
					state_reg <= ST_IDLE;
				end
			end
			ST_MEM: begin
				if (mem_done) begin
					if (mem_write) begin
						xfer_reg <= mem_reject;
					end else begin
						xfer_reg <= mem_corrected;
						response_data_reg <= mem_rdata;
						data_valid_reg <= 1'b1;
					end
					busy_reg <= 1'b0;
					state_reg <= ST_IDLE;
				end
			end
			default: begin
				busy_reg <= 1'b0;
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end
	// No-operation frames leave response_data_reg untouched, so it repeats
	wire unused_ok = is_nop | is_raw | is_rd | is_mst | is_wr | data_valid_reg;
endmodule // shcs_port

// ===== rtl/shcs_regs.vh
// Constants for the sensor host command and status port
`ifndef SHCS_REGS_VH
`define SHCS_REGS_VH
// Status byte fields
`define SHCS_ST_ZERO 7
`define SHCS_ST_POWER 6
`define SHCS_ST_BUSY 5
`define SHCS_ST_MODE_HI 4
`define SHCS_ST_MODE_LO 3
`define SHCS_ST_MEMERR 2
`define SHCS_ST_XFER 1
`define SHCS_ST_SAT 0
`define SHCS_MODE_NORMAL 2'h0
`define SHCS_MODE_CMD 2'h1
// Command codes
`define SHCS_CMD_RAW_BASE 8'hA0
`define SHCS_CMD_RAW_MASK 8'hF8
`define SHCS_CMD_NOP_BASE 8'hF0
`define SHCS_CMD_NOP_MASK 8'hF0
`define SHCS_CMD_RD_MAX 8'h17
`define SHCS_CMD_MST_BASE 8'h20
`define SHCS_CMD_MST_MAX 8'h37
`define SHCS_CMD_WR_BASE 8'h40
`define SHCS_CMD_WR_MAX 8'h57
`define SHCS_CMD_PAGE_INC 8'h5E
`define SHCS_CMD_START_NOM 8'hA8
`define SHCS_CMD_START_CM 8'hA9
`define SHCS_CMD_MEASURE 8'hAC
// Interface configuration word fields
`define SHCS_CFG_CPOL 11
`define SHCS_CFG_CPHA 10
`define SHCS_CFG_SSPOL 9
`define SHCS_TEMP_SETUP_MSB 12
`define SHCS_LAST_PAGE 2'h3
// Conversion type encoding on the measurement request
`define SHCS_CONV_BRIDGE 2'h0
`define SHCS_CONV_BRIDGE_AZ 2'h1
`define SHCS_CONV_TEMP 2'h2
`define SHCS_CONV_TEMP_AZ 2'h3
`endif

// ===== rtl/shcs_spi_shift.v
// SPI slave shifter: mode 0..3 and select polarity, 24-bit frames
`timescale 1ns/100ps
module shcs_spi_shift (
	input wire clock,
	input wire rst_n,
	input wire clk_en,
	input wire sclk_s,
	input wire ss_s,
	input wire mosi_s,
	input wire cpol,
	input wire cpha,
	input wire ss_active_high,
	input wire [23:0] tx_word,
	output reg miso_reg,
	output wire sel_active,
	output reg frame_start,
	output reg frame_end,
	output reg [23:0] rx_reg,
	output reg [4:0] rx_count_reg
);
	reg sclk_prev_reg;
	reg sel_prev_reg;
	reg [23:0] tx_sh_reg;
	reg [1:0] warm_reg;
	wire sclk_n;
	wire lead_edge;
	wire trail_edge;
	wire sample_edge;
	wire shift_edge;
	assign sel_active = ss_active_high ? ss_s : ~ss_s;
	assign sclk_n = sclk_s ^ cpol;
	assign lead_edge = sclk_n & ~sclk_prev_reg;
	assign trail_edge = ~sclk_n & sclk_prev_reg;
	assign sample_edge = cpha ? trail_edge : lead_edge;
	assign shift_edge = cpha ? lead_edge : trail_edge;
	always @(posedge clock) begin
		if (!rst_n) begin
			sclk_prev_reg <= 1'b0;
			sel_prev_reg <= 1'b0;
			warm_reg <= 2'h0;
			tx_sh_reg <= 24'h00_0000;
			miso_reg <= 1'b0;
			frame_start <= 1'b0;
			frame_end <= 1'b0;
			rx_reg <= 24'h00_0000;
			rx_count_reg <= 5'h00;
		end else if (clk_en) begin
			sclk_prev_reg <= sclk_n;
			sel_prev_reg <= sel_active;
			// Synchronisers hold reset values for two cycles: no edges until they settle
			if (warm_reg != 2'h3) begin
				warm_reg <= warm_reg + 2'h1;
				frame_start <= 1'b0;
				frame_end <= 1'b0;
			end else begin
			frame_start <= sel_active & ~sel_prev_reg;
			frame_end <= ~sel_active & sel_prev_reg;
			if (sel_active & ~sel_prev_reg) begin
				tx_sh_reg <= {tx_word[22:0], 1'b0};
				miso_reg <= tx_word[23];
				rx_count_reg <= 5'h00;
			end else if (sel_active) begin
				if (sample_edge) begin
					rx_reg <= {rx_reg[22:0], mosi_s};
					if (rx_count_reg != 5'h18)
						rx_count_reg <= rx_count_reg + 5'h01;
				end
				if (shift_edge && !(cpha && rx_count_reg == 5'h00)) begin
					miso_reg <= tx_sh_reg[23];
					tx_sh_reg <= {tx_sh_reg[22:0], 1'b0};
				end
			end
			end
		end
	end
endmodule // shcs_spi_shift

// ===== rtl/shcs_sync.v
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module shcs_sync #(
	parameter WIDTH = 4
) (
	input wire clock,
	input wire rst_n,
	input wire clk_en,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;
	always @(posedge clock) begin
		if (!rst_n) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else if (clk_en) begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule // shcs_sync
